// file: rtl/pwmpm_top.sv
// Pulse-width meter and PWM channel, top level
//
// Function
// - Measure high or low width of function input as selected.
// - Widths in 0.1us ticks, valid 2000..2147483647; beyond raises code 3200.
// - After overflow resume on new target level or start command restart.
// - Resume keeps fault code; only fault-clear command clears it.
// - Result refreshed every 1ms; latest width of interval shown.
// - Width granularity follows filter time: 50, 500, 5000, 5000, 10000, 50000.
// - Start command clears stored width, then sets active flag.
// - Start command released clears measurement active flag.
// - Interval begun before flag set is not measured.
// - Status bit follows function input level.
// - PWM up to 200kHz only on first match output.
// - High time accepted as 0 or 10..10000000 ticks.
// - Period accepted from 50 through 10000000 ticks.
// - Period lasts period setting, high for high-time setting.
// - Settings captured at run start; later changes ignored.
// - PWM waveform starts low.
// - Run command sets PWM active flag and keeps generating.
// - Run release stops waveform and clears PWM active flag.
`timescale 1ns/10ps
`default_nettype none
module pwmpm_top
  import pwmpm_pkg::*;
#(
  parameter int unsigned REFRESH_CYC = REFRESH_TICKS * TICK_CYC,
  // Overflow point of the width counter; a bench may lower it to reach the error path
  parameter logic [31:0] WIDTH_LIMIT = WIDTH_MAX
)
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              func_in,
  input  wire logic              meas_target_high,
  input  wire pwmpm_pkg::pwmpm_flt_t filter_sel,
  input  wire logic              width_meas_go_cmd,
  input  wire logic              fault_clear_cmd,
  input  wire logic              pwm_mode,
  input  wire logic              pwm_launch_instr,
  input  wire logic [23:0]       pwm_high_set,
  input  wire logic [23:0]       pwm_period_set,
  output logic [31:0]            width_result,
  output logic                   width_meas_active_flag,
  output logic                   func_input_level_bit,
  output logic [15:0]            channel_fault_code,
  output logic                   pwm_setting_error,
  output logic                   pwm_out,
  output logic                   pwm_active_flag
);
  import pwmpm_pkg::*;

  // Refuse settings that the dividers or the width counter cannot serve
  if (TICK_CYC < 1 || TICK_CYC > 64) begin : g_bad_tick
    $error("pwmpm_top: tick divider cannot serve this clock");
  end
  if (REFRESH_CYC < 2) begin : g_bad_refresh
    $error("pwmpm_top: refresh interval too short");
  end
  if (WIDTH_LIMIT < WIDTH_MIN) begin : g_bad_limit
    $error("pwmpm_top: width limit below the smallest valid width");
  end

  typedef struct packed {
    pwmpm_mstate_t st;
    logic [5:0]    tdiv;
    logic [31:0]   rdiv;
    logic [31:0]   wcnt;
    logic [31:0]   last;
    logic          have_new;
    logic [31:0]   result;
    logic          active;
    logic          cleared;
    logic          prev_in;
    logic [15:0]   fault;
    logic          serr;
  } pwmpm_st_t;

  pwmpm_st_t s_q;
  pwmpm_st_t s_d;

  logic        tick;
  logic        refresh;
  logic        at_target;
  logic        seg_start;
  logic        seg_end;
  logic [31:0] gran;
  logic [31:0] snapped;
  logic        set_ok;
  logic        run_gated;

  // Tick and refresh enables from dividers
  assign tick    = (s_q.tdiv == 6'(TICK_CYC - 1));
  assign refresh = (s_q.rdiv == REFRESH_CYC - 1);

  // Target level and its edges
  assign at_target = (func_in == meas_target_high);
  assign seg_start = at_target && (s_q.prev_in != meas_target_high);
  assign seg_end   = !at_target && (s_q.prev_in == meas_target_high);

  // Granularity table per filter time
  always_comb begin
    case (filter_sel)
      PWMPM_FLT_100US: gran = GRAN_100US;
      PWMPM_FLT_1MS:   gran = GRAN_1MS;
      PWMPM_FLT_5MS:   gran = GRAN_5MS;
      PWMPM_FLT_10MS:  gran = GRAN_5MS;
      PWMPM_FLT_20MS:  gran = GRAN_20MS;
      PWMPM_FLT_70MS:  gran = GRAN_70MS;
      default:         gran = GRAN_100US;
    endcase
  end

  // Width rounded down to the granularity; the divide is costly and combinational, its result taken once per pulse
  assign snapped = s_q.wcnt - (s_q.wcnt % gran);

  // Setting range check; a bad setting keeps the output off
  assign set_ok = ((pwm_high_set == 24'h000000) ||
                   (pwm_high_set >= PWM_HIGH_MIN && pwm_high_set <= PWM_LIM_MAX)) &&
                  (pwm_period_set >= PWM_PER_MIN && pwm_period_set <= PWM_LIM_MAX);
  assign run_gated = pwm_mode && pwm_launch_instr && (set_ok || pwm_active_flag);

  // Measurement state machine and result holding
  always_comb begin
    s_d         = s_q;
    s_d.prev_in = func_in;
    s_d.tdiv    = tick ? 6'h00 : s_q.tdiv + 6'h01;
    s_d.rdiv    = refresh ? 32'h0000_0000 : s_q.rdiv + 32'h0000_0001;
    s_d.serr    = pwm_mode && pwm_launch_instr && !set_ok && !pwm_active_flag;

    // Latest width only is presented at each refresh
    if (refresh && s_q.have_new) begin
      s_d.result   = s_q.last;
      s_d.have_new = 1'b0;
    end

    if (pwm_mode || !width_meas_go_cmd) begin
      s_d.st     = PWMPM_M_IDLE;
      s_d.active = 1'b0;
      s_d.cleared = 1'b0;
    end else begin
      case (s_q.st)
        PWMPM_M_IDLE: begin
          // Clear first, flag one cycle later
          s_d.result   = 32'h0000_0000;
          s_d.last     = 32'h0000_0000;
          s_d.have_new = 1'b0;
          s_d.cleared  = 1'b1;
          s_d.st       = PWMPM_M_ARM;
        end
        PWMPM_M_ARM: begin
          s_d.active = 1'b1;
          // Only a fresh target level after activation counts
          if (seg_start && s_q.active) begin
            s_d.wcnt = 32'h0000_0000;
            s_d.st   = PWMPM_M_RUN;
          end
        end
        PWMPM_M_RUN: begin
          if (seg_end) begin
            if (s_q.wcnt >= WIDTH_MIN) begin
              s_d.last     = snapped;
              s_d.have_new = 1'b1;
            end
            s_d.st = PWMPM_M_ARM;
          end else if (tick) begin
            if (s_q.wcnt == WIDTH_LIMIT) begin
              s_d.st    = PWMPM_M_OVF;
              s_d.fault = FAULT_RANGE_OVF;
            end else begin
              s_d.wcnt = s_q.wcnt + 32'h0000_0001;
            end
          end
        end
        PWMPM_M_OVF: begin
          // Resume on a new target level; fault code kept
          if (seg_start) begin
            s_d.wcnt = 32'h0000_0000;
            s_d.st   = PWMPM_M_RUN;
          end
        end
        default: s_d.st = PWMPM_M_IDLE;
      endcase
    end

    // Overflow in this cycle wins over a clear
    if (fault_clear_cmd && !(s_q.st == PWMPM_M_RUN && s_d.st == PWMPM_M_OVF)) begin
      s_d.fault = FAULT_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // PWM on the first match output only
  pwmpm_pwm_gen u_pwm (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .tick            (tick),
    .pwm_run_cmd     (run_gated),
    .pwm_high_set    (pwm_high_set),
    .pwm_period_set  (pwm_period_set),
    .pwm_out         (pwm_out),
    .pwm_active_flag (pwm_active_flag)
  );

  assign width_result           = s_q.result;
  assign width_meas_active_flag = s_q.active;
  assign func_input_level_bit   = s_q.prev_in;
  assign channel_fault_code     = s_q.fault;
  assign pwm_setting_error      = s_q.serr;

  // Checks on the measurement side

  // Width cleared the cycle before the active flag rises
  a_meas_clear_first: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(s_q.active) |-> s_q.result == 32'h0000_0000 && $past(s_q.cleared))
    else $error("active set before width cleared");

  // Releasing the start command drops the flag next cycle
  a_meas_stop_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !width_meas_go_cmd |=> !s_q.active)
    else $error("active flag not cleared");

  // Entering overflow always carries the range code
  a_ovf_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_q.st != PWMPM_M_OVF ##1 s_q.st == PWMPM_M_OVF |-> s_q.fault == FAULT_RANGE_OVF)
    else $error("overflow without code");

  // Overflow is reached from a running count only
  a_ovf_only_run: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_q.st != PWMPM_M_RUN && s_q.st != PWMPM_M_OVF |=> s_q.st != PWMPM_M_OVF)
    else $error("overflow without a running count");

  // Counter never passes the overflow point
  a_width_limit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_q.st == PWMPM_M_RUN |-> s_q.wcnt <= WIDTH_LIMIT)
    else $error("width count beyond limit");

  // A width below the valid range never reaches the held value
  a_result_min: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seg_end && s_q.st == PWMPM_M_RUN && s_q.wcnt < WIDTH_MIN |=> $stable(s_q.last))
    else $error("short width stored");

  // A fresh target level restarts counting after overflow
  a_ovf_resume: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pwm_mode && width_meas_go_cmd && s_q.st == PWMPM_M_OVF && seg_start |=> s_q.st == PWMPM_M_RUN)
    else $error("no resume after overflow");

  // Without a fresh target level the count stays stopped
  a_ovf_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_q.st == PWMPM_M_OVF && !seg_start |=> s_q.st != PWMPM_M_RUN)
    else $error("count resumed without target level");

  // Code survives resume; only the clear command drops it
  a_fault_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_q.fault != FAULT_NONE && !fault_clear_cmd |=> s_q.fault == $past(s_q.fault))
    else $error("fault code changed without clear");

  // Clear command works whenever no overflow can land
  a_fault_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fault_clear_cmd && s_q.st != PWMPM_M_RUN |=> s_q.fault == FAULT_NONE)
    else $error("fault code not cleared");

  // Outside idle the result moves only at a refresh point
  a_result_refresh: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !refresh && s_q.st != PWMPM_M_IDLE |=> $stable(s_q.result))
    else $error("result moved off refresh");

  // A refresh presents the latest stored width
  a_result_latest: assert property (@(posedge sys_clk) disable iff (sys_rst)
    refresh && s_q.have_new && s_q.st != PWMPM_M_IDLE |=> s_q.result == $past(s_q.last))
    else $error("refresh missed latest width");

  // Stored width is the count floored to the granularity
  a_width_floor: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pwm_mode && width_meas_go_cmd && s_q.st == PWMPM_M_RUN && seg_end && s_q.wcnt >= WIDTH_MIN |=>
    s_q.last % $past(gran) == 32'h0000_0000 && $past(s_q.wcnt) - s_q.last < $past(gran))
    else $error("width not floored to granularity");

  // No counting may start before the flag reads one
  a_arm_no_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_q.st == PWMPM_M_ARM && !s_q.active |=> s_q.st != PWMPM_M_RUN)
    else $error("count started before active flag");

  // Leaving the target level ends the count
  a_target_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pwm_mode && width_meas_go_cmd && s_q.st == PWMPM_M_RUN && seg_end |=> s_q.st == PWMPM_M_ARM)
    else $error("count ran past target level");

  // Status bit is the input one cycle late
  a_level_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> func_input_level_bit == $past(func_in))
    else $error("level bit lags");

  // Checks on the PWM side

  // A bad setting never starts the generator
  a_pwm_bad_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pwm_active_flag && !set_ok |=> !pwm_active_flag)
    else $error("bad setting started pwm");

  // A refused start is reported
  a_pwm_serr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pwm_mode && pwm_launch_instr && !set_ok && !pwm_active_flag |=> pwm_setting_error)
    else $error("refused start not reported");

  // Accepted start raises the flag with the output low
  a_pwm_run_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    run_gated && !pwm_active_flag |=> pwm_active_flag && !pwm_out)
    else $error("pwm flag not raised");

  // Output idles outside PWM mode
  a_pwm_mode_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pwm_mode |=> !pwm_out && !pwm_active_flag)
    else $error("pwm output outside pwm mode");

endmodule : pwmpm_top
`default_nettype wire

// file: rtl/pwmpm_pkg.sv
// Shared constants and types for the pulse-width meter and PWM channel
package pwmpm_pkg;

  // Base time unit 0.1us and system clock rate
  localparam int unsigned SYS_CLK_HZ        = 40000000;
  localparam int unsigned TICK_NS           = 100;
  localparam int unsigned TICK_CYC          = (SYS_CLK_HZ / 1000000) * TICK_NS / 1000;
  // Result refresh interval, 1ms in ticks
  localparam int unsigned REFRESH_US        = 1000;
  localparam int unsigned REFRESH_TICKS     = REFRESH_US * 1000 / TICK_NS;

  // Width measurement limits in ticks
  localparam logic [31:0] WIDTH_MIN         = 32'h0000_07D0;
  localparam logic [31:0] WIDTH_MAX         = 32'h7FFF_FFFF;
  localparam logic [15:0] FAULT_RANGE_OVF   = 16'h0C80;
  localparam logic [15:0] FAULT_NONE        = 16'h0000;

  // PWM setting limits in ticks
  localparam logic [23:0] PWM_HIGH_MIN      = 24'h00000A;
  localparam logic [23:0] PWM_PER_MIN       = 24'h000032;
  localparam logic [23:0] PWM_LIM_MAX       = 24'h989680;

  // Input filter time selections
  typedef enum logic [2:0] {
    PWMPM_FLT_100US,
    PWMPM_FLT_1MS,
    PWMPM_FLT_5MS,
    PWMPM_FLT_10MS,
    PWMPM_FLT_20MS,
    PWMPM_FLT_70MS
  } pwmpm_flt_t;

  // Granularity in ticks for each filter time
  localparam logic [31:0] GRAN_100US        = 32'h0000_0032;
  localparam logic [31:0] GRAN_1MS          = 32'h0000_01F4;
  localparam logic [31:0] GRAN_5MS          = 32'h0000_1388;
  localparam logic [31:0] GRAN_20MS         = 32'h0000_2710;
  localparam logic [31:0] GRAN_70MS         = 32'h0000_C350;

  typedef enum logic [1:0] {
    PWMPM_M_IDLE,
    PWMPM_M_ARM,
    PWMPM_M_RUN,
    PWMPM_M_OVF
  } pwmpm_mstate_t;

endpackage : pwmpm_pkg

// file: rtl/pwmpm_pwm_gen.sv
// PWM generator for the first match output
`timescale 1ns/10ps
`default_nettype none
module pwmpm_pwm_gen
  import pwmpm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        tick,
  input  wire logic        pwm_run_cmd,
  input  wire logic [23:0] pwm_high_set,
  input  wire logic [23:0] pwm_period_set,
  output logic             pwm_out,
  output logic             pwm_active_flag
);

  typedef struct packed {
    logic        run;
    logic [23:0] high;
    logic [23:0] per;
    logic [23:0] cnt;
    logic        out;
  } pwmpm_pwm_st_t;

  pwmpm_pwm_st_t s_q;
  pwmpm_pwm_st_t s_d;

  // Low part first, high part at the tail of each period
  always_comb begin
    s_d = s_q;
    if (!pwm_run_cmd) begin
      s_d.run = 1'b0;
      s_d.out = 1'b0;
      s_d.cnt = 24'h000000;
    end else if (!s_q.run) begin
      s_d.run  = 1'b1;
      s_d.high = pwm_high_set;
      s_d.per  = pwm_period_set;
      s_d.cnt  = 24'h000000;
      s_d.out  = 1'b0;
    end else if (tick) begin
      // Period wraps after per ticks; zero high time never rises
      if (s_q.cnt + 24'h000001 >= s_q.per) begin
        s_d.cnt = 24'h000000;
      end else begin
        s_d.cnt = s_q.cnt + 24'h000001;
      end
      s_d.out = (s_q.high != 24'h000000) &&
                (s_d.cnt >= s_q.per - s_q.high);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pwm_out         = s_q.out;
  assign pwm_active_flag = s_q.run;

  a_pwm_start_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(s_q.run) |-> !s_q.out) else $error("pwm did not start low");
  a_pwm_stop_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pwm_run_cmd |=> !s_q.run && !s_q.out) else $error("pwm did not stop");
  a_pwm_zero_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_q.run && s_q.high == 24'h000000 |-> !s_q.out) else $error("zero high drove output");
  a_pwm_hold_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_q.run && pwm_run_cmd |=> $stable(s_q.per) && $stable(s_q.high)) else $error("settings changed");

endmodule : pwmpm_pwm_gen
`default_nettype wire

// file: tb/pwmpm_far_end.sv
// Far-side model: pulse source on the function input and PWM load
`timescale 1ns/10ps
`default_nettype none
module pwmpm_far_end (
  input  wire logic sys_clk,
  input  wire logic pwm_out,
  output var logic  func_in,
  output var int    hi_len,
  output var int    per_len
);
  int   hi_cnt = 0;
  int   per_cnt = 0;
  logic out_q = 1'b0;

  initial func_in = 1'b0;

  // Idle level, changed off the sampling edge
  task automatic rest(input logic lvl);
    @(negedge sys_clk);
    func_in = lvl;
  endtask : rest

  // One level held for a whole count of cycles, then the inverse
  task automatic pulse(input logic lvl, input int cyc);
    @(negedge sys_clk);
    func_in = lvl;
    repeat (cyc) @(negedge sys_clk);
    func_in = ~lvl;
  endtask : pulse

  // Load: last high run and last rise-to-rise period in cycles
  always @(posedge sys_clk) begin
    out_q <= pwm_out;
    hi_cnt <= pwm_out ? hi_cnt + 1 : 0;
    per_cnt <= (pwm_out && !out_q) ? 1 : per_cnt + 1;
    if (!pwm_out && out_q) hi_len <= hi_cnt;
    if (pwm_out && !out_q) per_len <= per_cnt;
  end
endmodule : pwmpm_far_end
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the pulse-width meter and PWM channel
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pwmpm_pkg::*;
  // Short refresh keeps the run small; tick stays 4 cycles
  localparam int unsigned RCYC = 400;
  // Width limit cut to 3000 ticks so the overflow path is reachable
  localparam logic [31:0] WLIM = 32'h0000_0BB8;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        func_in;
  logic        tgt_high = 1'b1;
  pwmpm_flt_t  flt = PWMPM_FLT_100US;
  logic        go = 1'b0;
  logic        fclr = 1'b0;
  logic        pwm_mode = 1'b0;
  logic        launch = 1'b0;
  logic [23:0] hi_set = 24'h000000;
  logic [23:0] per_set = 24'h000032;
  logic [31:0] width_result;
  logic        meas_act;
  logic        lvl_bit;
  logic [15:0] fault;
  logic        set_err;
  logic        pwm_out;
  logic        pwm_act;
  int          hi_len;
  int          per_len;
  int          miscompares = 0;
  int          comparisons = 0;

  pwmpm_top #(.REFRESH_CYC(RCYC), .WIDTH_LIMIT(WLIM)) pwmpm_top_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .func_in(func_in), .meas_target_high(tgt_high),
    .filter_sel(flt), .width_meas_go_cmd(go), .fault_clear_cmd(fclr), .pwm_mode(pwm_mode),
    .pwm_launch_instr(launch), .pwm_high_set(hi_set), .pwm_period_set(per_set),
    .width_result(width_result), .width_meas_active_flag(meas_act), .func_input_level_bit(lvl_bit),
    .channel_fault_code(fault), .pwm_setting_error(set_err), .pwm_out(pwm_out), .pwm_active_flag(pwm_act));

  pwmpm_far_end pwmpm_far_end_i (
    .sys_clk(sys_clk), .pwm_out(pwm_out), .func_in(func_in), .hi_len(hi_len), .per_len(per_len));

  always #12.5 sys_clk = ~sys_clk;

  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Bounded wait on one of the two activity flags
  task automatic wait_flag(input bit sel_pwm, input logic want);
    for (int i = 0; i < 20; i++) begin
      @(negedge sys_clk);
      if ((sel_pwm ? pwm_act : meas_act) === want) return;
    end
    miscompares++;
    $display("wrong value flag wait expected %0h seen timeout", want);
    print_verdict();
  endtask : wait_flag

  // Start, one pulse, read after a refresh, stop; pre puts the pulse start before the start
  task automatic meas(input logic tgt, input pwmpm_flt_t f, input int cyc, input logic [31:0] exp,
                      input bit pre);
    @(negedge sys_clk);
    pwm_mode = 1'b0;
    tgt_high = tgt;
    flt = f;
    pwmpm_far_end_i.rest(pre ? tgt : ~tgt);
    repeat (8) @(negedge sys_clk);
    go = 1'b1;
    wait_flag(1'b0, 1'b1);
    check("cleared width", 32'h0, width_result);
    pwmpm_far_end_i.pulse(tgt, cyc);
    repeat (RCYC + 20) @(negedge sys_clk);
    check("width", exp, width_result);
    check("input level", {31'h0, ~tgt}, lvl_bit);
    check("fault code", 32'h0, fault);
    go = 1'b0;
    wait_flag(1'b0, 1'b0);
    $display("measure test done");
  endtask : meas

  // Run with given settings; bad expects a refusal
  task automatic pwm(input logic [23:0] hi, input logic [23:0] per, input bit bad);
    int ones;
    ones = 0;
    @(negedge sys_clk);
    pwm_mode = 1'b1;
    hi_set = hi;
    per_set = per;
    launch = 1'b1;
    if (bad) begin
      repeat (4) @(negedge sys_clk);
      check("setting error", 32'h1, set_err);
      check("refused flag", 32'h0, pwm_act);
    end else begin
      wait_flag(1'b1, 1'b1);
      check("first level", 32'h0, pwm_out);
      // Changed while running, must not take effect
      hi_set = per;
      per_set = per + 24'h000064;
      repeat (per * 12) begin
        @(negedge sys_clk);
        if (pwm_out !== 1'b0) ones++;
      end
      if (hi == 24'h000000) check("zero high", 32'h0, ones);
      else begin
        check("high time", hi * 4, hi_len);
        check("period", per * 4, per_len);
      end
    end
    launch = 1'b0;
    if (!bad) wait_flag(1'b1, 1'b0);
    check("stopped level", 32'h0, pwm_out);
    $display("pwm test done");
  endtask : pwm

  // Main sequence
  initial begin
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    check("reset width", 32'h0, width_result);
    check("reset flags", 32'h0, {meas_act, pwm_act, set_err, pwm_out});
    meas(1'b1, PWMPM_FLT_100US, 10320, 32'h0000_09F6, 1'b0);
    meas(1'b1, PWMPM_FLT_1MS, 10320, 32'h0000_09C4, 1'b0);
    meas(1'b0, PWMPM_FLT_100US, 10320, 32'h0000_09F6, 1'b0);
    meas(1'b1, PWMPM_FLT_100US, 4000, 32'h0, 1'b0);
    meas(1'b1, PWMPM_FLT_100US, 10320, 32'h0, 1'b1);
    // Overflow at the cut limit, then resume on a new target level
    @(negedge sys_clk);
    go = 1'b1;
    wait_flag(1'b0, 1'b1);
    pwmpm_far_end_i.pulse(1'b1, 12400);
    check("overflow code", 32'h0000_0C80, fault);
    check("overflow width", 32'h0, width_result);
    pwmpm_far_end_i.pulse(1'b1, 8520);
    repeat (RCYC + 20) @(negedge sys_clk);
    check("resumed width", 32'h0000_0834, width_result);
    check("kept code", 32'h0000_0C80, fault);
    fclr = 1'b1;
    @(negedge sys_clk);
    fclr = 1'b0;
    check("cleared fault", 32'h0, fault);
    go = 1'b0;
    wait_flag(1'b0, 1'b0);
    $display("overflow test done");
    pwm(24'h00000A, 24'h000032, 1'b0);
    pwm(24'h000064, 24'h000190, 1'b0);
    pwm(24'h000000, 24'h000032, 1'b0);
    pwm(24'h000005, 24'h000032, 1'b1);
    pwm(24'h00000A, 24'h000031, 1'b1);
    pwm(24'h00000A, 24'h989681, 1'b1);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
